//--- tb/iowm_host_card_model.sv
/*
 Far side model: host I/O cycle source and the card's width indication.
 Assumes the bench holds req high for each cycle a host I/O cycle is present.
*/
`timescale 1ns/100ps
module iowm_host_card_model (
   input wire logic pclk,
   input wire logic req,
   input wire iowm_pkg::iowm_addr_t req_addr,
   input wire logic req_w16,
   output logic io_valid,
   output iowm_pkg::iowm_addr_t io_addr,
   output logic card_io_width16_indication
);
   import iowm_pkg::*;
   initial begin
      io_valid = 1'b0;
      io_addr = 16'h0000;
      card_io_width16_indication = 1'b0;
   end
   // Released lines toggle, so a stale address never passes for a live one
   always @(posedge pclk) begin
      io_valid <= req;
      io_addr <= req ? req_addr : ~io_addr;
      card_io_width16_indication <= req ? req_w16 : ~card_io_width16_indication;
   end
endmodule : iowm_host_card_model

//--- tb/tb.sv
/*
 Bench for the I/O window mapper: APB register tests and window decode probes.
 Assumes the mapper answers APB with no wait states and decodes in one cycle.
*/
`timescale 1ns/100ps
module tb;
   import iowm_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, io_valid, ind, win_hit, width16, timing_set1, err;
   logic [1:0] win_sel;
   iowm_addr_t io_addr, card_addr;
   iowm_addr_t req_addr = 16'h0;
   logic req = 1'b0;
   logic req_w16 = 1'b0;
   logic [7:0] rd;
   int failures = 0;
   int n_compared = 0;
   int cyc = 0;
   logic [7:0] idx_t [13] = '{8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e,
      8'h0f, 8'h36, 8'h37, 8'h38, 8'h39};
   // Window 0 at 1200..12ff, offset bit 0 set on purpose; window 1 wraps
   logic [15:0] prog_t [12] = '{16'h0800, 16'h0912, 16'h0aff, 16'h0b12, 16'h3603,
      16'h3701, 16'h0cf0, 16'h0dff, 16'h0eff, 16'h0fff, 16'h3820, 16'h3900};
   always #10 pclk = ~pclk;
   iowm_mapper u_iowm_mapper (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .io_valid(io_valid),
      .io_addr(io_addr), .card_io_width16_indication(ind), .win_hit(win_hit),
      .win_sel(win_sel), .card_addr(card_addr), .width16(width16),
      .timing_set1(timing_set1));
   iowm_host_card_model u_iowm_host_card_model (.pclk(pclk), .req(req),
      .req_addr(req_addr), .req_w16(req_w16), .io_valid(io_valid), .io_addr(io_addr),
      .card_io_width16_indication(ind));
   task automatic finish_test();
      $display("Compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : finish_test
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %0t %s: saw %h expected %h", $time, what, seen, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {22'h0, idx, 2'b00};
      pwdata <= {24'h0, wd};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic probe(input logic [7:0] ctrl, input logic [7:0] en, input iowm_addr_t a,
      input logic w, input logic [1:0] sel, input iowm_addr_t card, input logic [1:0] wt);
      apb(1'b1, 8'h07, ctrl);
      apb(1'b1, 8'h40, en);
      @(posedge pclk);
      req <= 1'b1;
      req_addr <= a;
      req_w16 <= w;
      @(posedge pclk);
      req <= 1'b0;
      @(posedge pclk);
      @(negedge pclk);
      chk(win_hit, |sel, "claim");
      chk(win_sel, sel, "window select");
      if (|sel) chk(card_addr, card, "card address");
      chk({width16, timing_set1}, wt, "width and timing");
   endtask : probe
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 4000) begin
         failures++;
         finish_test();
      end
   end
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      foreach (idx_t[i]) begin
         apb(1'b0, idx_t[i], 8'h00);
         chk(rd, 8'h00, "reset value");
         apb(1'b1, idx_t[i], {idx_t[i][6:0], 1'b0});
         apb(1'b0, idx_t[i], 8'h00);
         chk(rd, {idx_t[i][6:0], 1'b0}, "read back");
         chk(err, 1'b0, "mapped access error");
      end
      apb(1'b1, 8'h20, 8'hff);
      chk(err, 1'b1, "unmapped write error");
      apb(1'b0, 8'h20, 8'h00);
      chk({err, rd}, 9'h100, "unmapped read");
      apb(1'b1, 8'h40, 8'hff);
      apb(1'b0, 8'h40, 8'h00);
      chk(rd, 8'h03, "enable spare bits");
      $display("Test registers done");
      foreach (prog_t[i]) apb(1'b1, prog_t[i][15:8], prog_t[i][7:0]);
      probe(8'h80, 8'h03, 16'h11ff, 1'b1, 2'b00, 16'h0000, 2'b00);
      probe(8'h80, 8'h03, 16'h1200, 1'b1, 2'b01, 16'h1302, 2'b00);
      probe(8'h80, 8'h03, 16'h12ff, 1'b0, 2'b01, 16'h1401, 2'b00);
      probe(8'h80, 8'h03, 16'h1300, 1'b1, 2'b00, 16'h0000, 2'b00);
      probe(8'h80, 8'h03, 16'hfff8, 1'b0, 2'b10, 16'h0018, 2'b01);
      probe(8'h1a, 8'h03, 16'h1200, 1'b1, 2'b01, 16'h1302, 2'b11);
      probe(8'h1a, 8'h03, 16'h1200, 1'b0, 2'b01, 16'h1302, 2'b01);
      probe(8'h1a, 8'h03, 16'hffff, 1'b0, 2'b10, 16'h001f, 2'b10);
      probe(8'h01, 8'h03, 16'h1280, 1'b0, 2'b01, 16'h1382, 2'b10);
      probe(8'h00, 8'h02, 16'h1200, 1'b1, 2'b00, 16'h0000, 2'b00);
      probe(8'h00, 8'h01, 16'hfff0, 1'b1, 2'b00, 16'h0000, 2'b00);
      probe(8'h20, 8'h03, 16'hfff8, 1'b1, 2'b10, 16'h0018, 2'b10);
      probe(8'h00, 8'h00, 16'h1200, 1'b1, 2'b00, 16'h0000, 2'b00);
      apb(1'b1, 8'h07, 8'h1a);
      apb(1'b1, 8'h40, 8'h03);
      @(posedge pclk);
      req <= 1'b1;
      req_addr <= 16'h1200;
      req_w16 <= 1'b1;
      repeat (2) @(posedge pclk);
      apb(1'b0, 8'h41, 8'h00);
      req <= 1'b0;
      chk(rd, 8'h0d, "status during claim");
      $display("Test decode done");
      finish_test();
   end
endmodule : tb

//--- verilog/iowm_mapper.sv
/*
 I/O window address mapper: APB register file for two I/O windows and
 the decode that claims host I/O cycles and forms card addresses.
 Assumes an APB master on pclk and a card cycle generator that samples
 the registered hit, address, width and timing-select outputs.
*/
// Summary of operation
// - Window 1 timing set from select bit 7
// - Claim only when start <= address <= end
// - Start address from low and high bytes
// - End address from low and high bytes
// - Card address is host address plus offset
// - Offset bit 0 always treated as zero
// - Two identical windows at distinct indexes
// - Window 0 timing set from select bit 3
// - Auto-size uses card width indication, else size
`timescale 1ns/100ps
`include "iowm_regs.svh"
module iowm_mapper #(
   parameter int NUM_WIN = 2
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic io_valid,
   input wire iowm_pkg::iowm_addr_t io_addr,
   input wire logic card_io_width16_indication,
   output logic win_hit,
   output logic [1:0] win_sel,
   output iowm_pkg::iowm_addr_t card_addr,
   output logic width16,
   output logic timing_set1
);
   import iowm_pkg::*;

   typedef struct packed {
      iowm_win_regs_t [NUM_WIN-1:0] win;
      iowm_byte_t ctrl;
      iowm_byte_t enable;
      logic [31:0] rdata;
      logic hit;
      logic [1:0] sel;
      iowm_addr_t caddr;
      logic w16;
      logic tsel;
   } iowm_state_t;

   iowm_state_t state;
   iowm_state_t next_state;
   logic [NUM_WIN-1:0] hits;
   iowm_addr_t caddrs [NUM_WIN];
   logic setup;
   logic access;
   logic [7:0] index;
   logic mapped;
   iowm_byte_t rbyte;

   // Ctrl bit index for a window field
   function automatic int ctrl_bit(input int win, input int field);
      return win * `IOWM_CTRL_WIN_STRIDE + field;
   endfunction : ctrl_bit

   genvar g;
   generate
      for (g = 0; g < NUM_WIN; g++) begin : gen_win
         iowm_window u_win (
            .regs(state.win[g]),
            .enable(state.enable[`IOWM_EN_W0 + g]),
            .host_addr(io_addr),
            .hit(hits[g]),
            .card_addr(caddrs[g])
         );
      end
   endgenerate

   assign setup = psel && !penable;
   assign access = psel && penable;
   assign index = paddr[`IOWM_WORD_SHIFT +: 8];

   // Read mux and map check; index 8 bits wide covers every register
   always_comb begin
      rbyte = `IOWM_RESET_BYTE;
      mapped = 1'b1;
      unique case (index)
         `IOWM_IDX_CTRL: rbyte = state.ctrl;
         `IOWM_IDX_W0_START_LO: rbyte = state.win[0].start_lo;
         `IOWM_IDX_W0_START_HI: rbyte = state.win[0].start_hi;
         `IOWM_IDX_W0_END_LO: rbyte = state.win[0].end_lo;
         `IOWM_IDX_W0_END_HI: rbyte = state.win[0].end_hi;
         `IOWM_IDX_W1_START_LO: rbyte = state.win[1].start_lo;
         `IOWM_IDX_W1_START_HI: rbyte = state.win[1].start_hi;
         `IOWM_IDX_W1_END_LO: rbyte = state.win[1].end_lo;
         `IOWM_IDX_W1_END_HI: rbyte = state.win[1].end_hi;
         `IOWM_IDX_W0_OFS_LO: rbyte = state.win[0].ofs_lo;
         `IOWM_IDX_W0_OFS_HI: rbyte = state.win[0].ofs_hi;
         `IOWM_IDX_W1_OFS_LO: rbyte = state.win[1].ofs_lo;
         `IOWM_IDX_W1_OFS_HI: rbyte = state.win[1].ofs_hi;
         `IOWM_IDX_ENABLE: rbyte = state.enable;
         `IOWM_IDX_STATUS: rbyte = {4'h0, state.tsel, state.w16, state.sel};
         default: mapped = 1'b0;
      endcase
   end

   always_comb begin
      next_state = state;
      // Read data captured in setup so it is steady through access
      if (setup) begin
         next_state.rdata = {24'h000000, rbyte};
      end
      if (access && pwrite && mapped) begin
         unique case (index)
            `IOWM_IDX_CTRL: next_state.ctrl = pwdata[7:0];
            `IOWM_IDX_W0_START_LO: next_state.win[0].start_lo = pwdata[7:0];
            `IOWM_IDX_W0_START_HI: next_state.win[0].start_hi = pwdata[7:0];
            `IOWM_IDX_W0_END_LO: next_state.win[0].end_lo = pwdata[7:0];
            `IOWM_IDX_W0_END_HI: next_state.win[0].end_hi = pwdata[7:0];
            `IOWM_IDX_W1_START_LO: next_state.win[1].start_lo = pwdata[7:0];
            `IOWM_IDX_W1_START_HI: next_state.win[1].start_hi = pwdata[7:0];
            `IOWM_IDX_W1_END_LO: next_state.win[1].end_lo = pwdata[7:0];
            `IOWM_IDX_W1_END_HI: next_state.win[1].end_hi = pwdata[7:0];
            // Bit 0 stored as written, but the adder never reads it
            `IOWM_IDX_W0_OFS_LO: next_state.win[0].ofs_lo = pwdata[7:0];
            `IOWM_IDX_W0_OFS_HI: next_state.win[0].ofs_hi = pwdata[7:0];
            `IOWM_IDX_W1_OFS_LO: next_state.win[1].ofs_lo = pwdata[7:0];
            `IOWM_IDX_W1_OFS_HI: next_state.win[1].ofs_hi = pwdata[7:0];
            `IOWM_IDX_ENABLE: next_state.enable = {6'h00, pwdata[1:0]};
            default: next_state.enable = state.enable;
         endcase
      end
      // Window 0 wins if software lets the two windows overlap
      next_state.hit = 1'b0;
      next_state.sel = 2'h0;
      next_state.caddr = state.caddr;
      next_state.w16 = 1'b0;
      next_state.tsel = 1'b0;
      if (io_valid) begin
         for (int w = NUM_WIN - 1; w >= 0; w--) begin
            if (hits[w]) begin
               next_state.hit = 1'b1;
               next_state.sel = 2'(1 << w);
               next_state.caddr = caddrs[w];
               next_state.w16 = state.ctrl[ctrl_bit(w, `IOWM_CTRL_AUTO0)] ?
                  card_io_width16_indication :
                  state.ctrl[ctrl_bit(w, `IOWM_CTRL_SIZE0)];
               next_state.tsel = state.ctrl[ctrl_bit(w, `IOWM_CTRL_TSEL0)];
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign pready = 1'b1;
   assign pslverr = access && !mapped;
   assign prdata = state.rdata;
   assign win_hit = state.hit;
   assign win_sel = state.sel;
   assign card_addr = state.caddr;
   assign width16 = state.w16;
   assign timing_set1 = state.tsel;

   // Decode outputs, one cycle behind the host sample
   AST_W1_TIMING: assert property (@(posedge pclk) disable iff (!presetn)
      (io_valid && hits[1] && !hits[0]) |=> (timing_set1 == $past(state.ctrl[7])))
      else $error("window 1 timing select wrong");
   AST_W0_TIMING: assert property (@(posedge pclk) disable iff (!presetn)
      (io_valid && hits[0]) |=> (timing_set1 == $past(state.ctrl[3])))
      else $error("window 0 timing select wrong");
   AST_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
      win_sel[0] |-> ($past(io_addr) >= $past({state.win[0].start_hi, state.win[0].start_lo})
      && $past(io_addr) <= $past({state.win[0].end_hi, state.win[0].end_lo})))
      else $error("hit outside window 0 range");
   AST_RANGE_W1: assert property (@(posedge pclk) disable iff (!presetn)
      win_sel[1] |-> ($past(io_addr) >= $past({state.win[1].start_hi, state.win[1].start_lo})
      && $past(io_addr) <= $past({state.win[1].end_hi, state.win[1].end_lo})))
      else $error("hit outside window 1 range");
   AST_CLAIM_W0: assert property (@(posedge pclk) disable iff (!presetn)
      (io_valid && state.enable[0]
      && io_addr >= {state.win[0].start_hi, state.win[0].start_lo}
      && io_addr <= {state.win[0].end_hi, state.win[0].end_lo}) |=> (win_sel == 2'b01))
      else $error("window 0 cycle not claimed");
   AST_CLAIM_W1: assert property (@(posedge pclk) disable iff (!presetn)
      (io_valid && state.enable[1] && !hits[0]
      && io_addr >= {state.win[1].start_hi, state.win[1].start_lo}
      && io_addr <= {state.win[1].end_hi, state.win[1].end_lo}) |=> (win_sel == 2'b10))
      else $error("window 1 cycle not claimed");
   AST_NO_VALID: assert property (@(posedge pclk) disable iff (!presetn)
      !io_valid |=> !win_hit)
      else $error("hit without host cycle");
   AST_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
      !win_hit |-> (win_sel == 2'h0 && !width16 && !timing_set1))
      else $error("window outputs active without a claim");
   AST_DISABLED: assert property (@(posedge pclk) disable iff (!presetn)
      (state.enable[1:0] == 2'h0) |=> !win_hit)
      else $error("hit on disabled windows");
   AST_DISABLED_W0: assert property (@(posedge pclk) disable iff (!presetn)
      (io_valid && !state.enable[0]) |=> !win_sel[0])
      else $error("disabled window 0 claimed");
   AST_DISABLED_W1: assert property (@(posedge pclk) disable iff (!presetn)
      (io_valid && !state.enable[1]) |=> !win_sel[1])
      else $error("disabled window 1 claimed");
   AST_OFFSET: assert property (@(posedge pclk) disable iff (!presetn)
      win_sel[0] |-> card_addr == 16'($past(io_addr) +
      {$past(state.win[0].ofs_hi), $past(state.win[0].ofs_lo[7:1]), 1'b0}))
      else $error("card address sum wrong");
   AST_OFFSET_W1: assert property (@(posedge pclk) disable iff (!presetn)
      win_sel[1] |-> card_addr == 16'($past(io_addr) +
      {$past(state.win[1].ofs_hi), $past(state.win[1].ofs_lo[7:1]), 1'b0}))
      else $error("window 1 card address sum wrong");
   AST_CADDR_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      !(io_valid && (|hits)) |=> (card_addr == $past(card_addr)))
      else $error("card address moved without a claim");
   AST_LSB_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
      (win_hit && !$past(io_addr[0])) |-> !card_addr[0])
      else $error("offset bit 0 leaked");
   AST_AUTOSIZE: assert property (@(posedge pclk) disable iff (!presetn)
      (io_valid && hits[0] && state.ctrl[1]) |=> width16 == $past(card_io_width16_indication))
      else $error("auto size width wrong");
   AST_SIZE_W0: assert property (@(posedge pclk) disable iff (!presetn)
      (io_valid && hits[0] && !state.ctrl[1]) |=> (width16 == $past(state.ctrl[0])))
      else $error("window 0 fixed width wrong");
   AST_SIZE_W1: assert property (@(posedge pclk) disable iff (!presetn)
      (io_valid && hits[1] && !hits[0] && !state.ctrl[5])
      |=> (width16 == $past(state.ctrl[4])))
      else $error("window 1 fixed width wrong");
   AST_AUTOSIZE_W1: assert property (@(posedge pclk) disable iff (!presetn)
      (io_valid && hits[1] && !hits[0] && state.ctrl[5])
      |=> (width16 == $past(card_io_width16_indication)))
      else $error("window 1 auto width wrong");
   AST_ONEHOT: assert property (@(posedge pclk) disable iff (!presetn)
      win_hit |-> $onehot(win_sel))
      else $error("window select not one hot");

   // Register file: writes land at the access edge
   AST_WR_W0_START_LO: assert property (@(posedge pclk) disable iff (!presetn)
      (access && pwrite && index == `IOWM_IDX_W0_START_LO)
      |=> (state.win[0].start_lo == $past(pwdata[7:0])))
      else $error("window 0 start low write lost");
   AST_WR_W0_START_HI: assert property (@(posedge pclk) disable iff (!presetn)
      (access && pwrite && index == `IOWM_IDX_W0_START_HI)
      |=> (state.win[0].start_hi == $past(pwdata[7:0])))
      else $error("window 0 start high write lost");
   AST_WR_W0_END_LO: assert property (@(posedge pclk) disable iff (!presetn)
      (access && pwrite && index == `IOWM_IDX_W0_END_LO)
      |=> (state.win[0].end_lo == $past(pwdata[7:0])))
      else $error("window 0 end low write lost");
   AST_WR_W0_END_HI: assert property (@(posedge pclk) disable iff (!presetn)
      (access && pwrite && index == `IOWM_IDX_W0_END_HI)
      |=> (state.win[0].end_hi == $past(pwdata[7:0])))
      else $error("window 0 end high write lost");
   AST_WR_W1_START_LO: assert property (@(posedge pclk) disable iff (!presetn)
      (access && pwrite && index == `IOWM_IDX_W1_START_LO)
      |=> (state.win[1].start_lo == $past(pwdata[7:0])))
      else $error("window 1 start low write lost");
   AST_WR_W1_START_HI: assert property (@(posedge pclk) disable iff (!presetn)
      (access && pwrite && index == `IOWM_IDX_W1_START_HI)
      |=> (state.win[1].start_hi == $past(pwdata[7:0])))
      else $error("window 1 start high write lost");
   AST_WR_W1_END_LO: assert property (@(posedge pclk) disable iff (!presetn)
      (access && pwrite && index == `IOWM_IDX_W1_END_LO)
      |=> (state.win[1].end_lo == $past(pwdata[7:0])))
      else $error("window 1 end low write lost");
   AST_WR_W1_END_HI: assert property (@(posedge pclk) disable iff (!presetn)
      (access && pwrite && index == `IOWM_IDX_W1_END_HI)
      |=> (state.win[1].end_hi == $past(pwdata[7:0])))
      else $error("window 1 end high write lost");
   AST_WR_W0_OFS_LO: assert property (@(posedge pclk) disable iff (!presetn)
      (access && pwrite && index == `IOWM_IDX_W0_OFS_LO)
      |=> (state.win[0].ofs_lo == $past(pwdata[7:0])))
      else $error("window 0 offset low write lost");
   AST_WR_W0_OFS_HI: assert property (@(posedge pclk) disable iff (!presetn)
      (access && pwrite && index == `IOWM_IDX_W0_OFS_HI)
      |=> (state.win[0].ofs_hi == $past(pwdata[7:0])))
      else $error("window 0 offset high write lost");
   AST_WR_W1_OFS_LO: assert property (@(posedge pclk) disable iff (!presetn)
      (access && pwrite && index == `IOWM_IDX_W1_OFS_LO)
      |=> (state.win[1].ofs_lo == $past(pwdata[7:0])))
      else $error("window 1 offset low write lost");
   AST_WR_W1_OFS_HI: assert property (@(posedge pclk) disable iff (!presetn)
      (access && pwrite && index == `IOWM_IDX_W1_OFS_HI)
      |=> (state.win[1].ofs_hi == $past(pwdata[7:0])))
      else $error("window 1 offset high write lost");
   AST_WR_CTRL: assert property (@(posedge pclk) disable iff (!presetn)
      (access && pwrite && index == `IOWM_IDX_CTRL)
      |=> (state.ctrl == $past(pwdata[7:0])))
      else $error("control write lost");
   AST_WR_ENABLE: assert property (@(posedge pclk) disable iff (!presetn)
      (access && pwrite && index == `IOWM_IDX_ENABLE)
      |=> (state.enable == {6'h00, $past(pwdata[1:0])}))
      else $error("enable write lost");
   AST_WR_UNMAPPED: assert property (@(posedge pclk) disable iff (!presetn)
      (access && pwrite && !mapped)
      |=> ($stable(state.win) && $stable(state.ctrl) && $stable(state.enable)))
      else $error("unmapped write changed a register");

   // Read data is taken at setup so it stands through access
   AST_RD_W0_START_LO: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && index == `IOWM_IDX_W0_START_LO)
      |=> (prdata == {24'h000000, $past(state.win[0].start_lo)}))
      else $error("window 0 start low read wrong");
   AST_RD_W0_START_HI: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && index == `IOWM_IDX_W0_START_HI)
      |=> (prdata == {24'h000000, $past(state.win[0].start_hi)}))
      else $error("window 0 start high read wrong");
   AST_RD_W0_END_LO: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && index == `IOWM_IDX_W0_END_LO)
      |=> (prdata == {24'h000000, $past(state.win[0].end_lo)}))
      else $error("window 0 end low read wrong");
   AST_RD_W0_END_HI: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && index == `IOWM_IDX_W0_END_HI)
      |=> (prdata == {24'h000000, $past(state.win[0].end_hi)}))
      else $error("window 0 end high read wrong");
   AST_RD_W0_OFS_LO: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && index == `IOWM_IDX_W0_OFS_LO)
      |=> (prdata == {24'h000000, $past(state.win[0].ofs_lo)}))
      else $error("window 0 offset low read wrong");
   AST_RD_W0_OFS_HI: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && index == `IOWM_IDX_W0_OFS_HI)
      |=> (prdata == {24'h000000, $past(state.win[0].ofs_hi)}))
      else $error("window 0 offset high read wrong");
   AST_RD_W1_START_LO: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && index == `IOWM_IDX_W1_START_LO)
      |=> (prdata == {24'h000000, $past(state.win[1].start_lo)}))
      else $error("window 1 start low read wrong");
   AST_RD_W1_END_LO: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && index == `IOWM_IDX_W1_END_LO)
      |=> (prdata == {24'h000000, $past(state.win[1].end_lo)}))
      else $error("window 1 end low read wrong");
   AST_RD_W1_END_HI: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && index == `IOWM_IDX_W1_END_HI)
      |=> (prdata == {24'h000000, $past(state.win[1].end_hi)}))
      else $error("window 1 end high read wrong");
   AST_RD_W1_OFS_HI: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && index == `IOWM_IDX_W1_OFS_HI)
      |=> (prdata == {24'h000000, $past(state.win[1].ofs_hi)}))
      else $error("window 1 offset high read wrong");
endmodule : iowm_mapper

//--- verilog/iowm_pkg.sv
/*
 Types shared by the I/O window mapper files.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package iowm_pkg;
   typedef logic [7:0] iowm_byte_t;
   typedef logic [15:0] iowm_addr_t;
   typedef struct packed {
      iowm_byte_t start_lo;
      iowm_byte_t start_hi;
      iowm_byte_t end_lo;
      iowm_byte_t end_hi;
      iowm_byte_t ofs_lo;
      iowm_byte_t ofs_hi;
   } iowm_win_regs_t;
endpackage : iowm_pkg

//--- verilog/iowm_regs.svh
/*
 Register indexes, field positions and reset values of the I/O window mapper.
 Assumes inclusion by bare name from every file that needs the map.
*/
`ifndef IOWM_REGS_SVH
`define IOWM_REGS_SVH
// Printed indexes; byte address is four times the index
`define IOWM_IDX_CTRL 8'h07
`define IOWM_IDX_W0_START_LO 8'h08
`define IOWM_IDX_W0_START_HI 8'h09
`define IOWM_IDX_W0_END_LO 8'h0a
`define IOWM_IDX_W0_END_HI 8'h0b
`define IOWM_IDX_W1_START_LO 8'h0c
`define IOWM_IDX_W1_START_HI 8'h0d
`define IOWM_IDX_W1_END_LO 8'h0e
`define IOWM_IDX_W1_END_HI 8'h0f
`define IOWM_IDX_W0_OFS_LO 8'h36
`define IOWM_IDX_W0_OFS_HI 8'h37
`define IOWM_IDX_W1_OFS_LO 8'h38
`define IOWM_IDX_W1_OFS_HI 8'h39
`define IOWM_IDX_ENABLE 8'h40
`define IOWM_IDX_STATUS 8'h41
// Control register fields, window 1 sits four bits above window 0
`define IOWM_CTRL_SIZE0 0
`define IOWM_CTRL_AUTO0 1
`define IOWM_CTRL_TSEL0 3
`define IOWM_CTRL_WIN_STRIDE 4
// Enable register fields
`define IOWM_EN_W0 0
`define IOWM_EN_W1 1
// Status register fields
`define IOWM_ST_HIT0 0
`define IOWM_ST_HIT1 1
`define IOWM_ST_W16 2
`define IOWM_ST_TSEL 3
`define IOWM_RESET_BYTE 8'h00
`define IOWM_WORD_SHIFT 2
`endif

//--- verilog/iowm_window.sv
/*
 One I/O window: range compare and card address formation.
 Assumes register contents arrive already stable from the register file.
*/
`timescale 1ns/100ps
`include "iowm_regs.svh"
module iowm_window (
   input wire iowm_pkg::iowm_win_regs_t regs,
   input wire logic enable,
   input wire iowm_pkg::iowm_addr_t host_addr,
   output logic hit,
   output iowm_pkg::iowm_addr_t card_addr
);
   import iowm_pkg::*;
   iowm_addr_t start_addr;
   iowm_addr_t end_addr;
   iowm_addr_t offset;
   assign start_addr = {regs.start_hi, regs.start_lo};
   assign end_addr = {regs.end_hi, regs.end_lo};
   assign offset = {regs.ofs_hi, regs.ofs_lo[7:1], 1'b0};
   // Inclusive on both ends, so start equal end gives a one-port window
   assign hit = enable && (host_addr >= start_addr) && (host_addr <= end_addr);
   // 16-bit sum truncates the carry by width
   assign card_addr = host_addr + offset;
endmodule : iowm_window
